// File: common/mtam_pkg.sv
// Constants, register map and carrier types of the muting supervisor
`default_nettype none
package mtam_pkg;

	// Timebase: the clock rate and the millisecond derived from it
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned S_PER_MIN       = 60;
	localparam int unsigned CYC_PER_MS_DFLT = CLK_HZ / MS_PER_S;

	// Documented default times in their own units
	localparam int unsigned SEQ_GAP_DFLT_MS   = 0;
	localparam int unsigned PAR_MIN_DFLT_MS   = 0;
	localparam int unsigned PAR_MAX_DFLT_MS   = 2500;
	localparam int unsigned LIMIT_DFLT_MIN    = 10;
	localparam int unsigned ON_TIME_DFLT_MS   = 0;
	localparam int unsigned OFF_TIME_DFLT_MS  = 100;
	localparam int unsigned AUTO_RESTART_S    = 10;

	// Millisecond figures loaded into the time registers, then the fixed self-reset time and the limit-off value
	localparam logic [31:0] RST_SEQ_GAP  = 32'(SEQ_GAP_DFLT_MS);
	localparam logic [31:0] RST_PAR_MIN  = 32'(PAR_MIN_DFLT_MS);
	localparam logic [31:0] RST_PAR_MAX  = 32'(PAR_MAX_DFLT_MS);
	localparam logic [31:0] RST_LIMIT    = 32'(LIMIT_DFLT_MIN * S_PER_MIN * MS_PER_S);
	localparam logic [31:0] RST_ON_TIME  = 32'(ON_TIME_DFLT_MS);
	localparam logic [31:0] RST_OFF_TIME = 32'(OFF_TIME_DFLT_MS);
	localparam logic [31:0] AUTO_RST_MS  = 32'(AUTO_RESTART_S * MS_PER_S);
	localparam logic [31:0] LIMIT_OFF    = 32'h0000_0000;

	// Register word addresses
	localparam int unsigned ADDR_W       = 3;
	localparam logic [2:0]  ADDR_CTRL    = 3'h0;
	localparam logic [2:0]  ADDR_SEQ_GAP = 3'h1;
	localparam logic [2:0]  ADDR_PAR_MIN = 3'h2;
	localparam logic [2:0]  ADDR_PAR_MAX = 3'h3;
	localparam logic [2:0]  ADDR_LIMIT   = 3'h4;
	localparam logic [2:0]  ADDR_ON_TIME = 3'h5;
	localparam logic [2:0]  ADDR_OFF_TIM = 3'h6;
	localparam logic [2:0]  ADDR_STATUS  = 3'h7;

	// Basic configuration codes: sensor roles onto input lines
	typedef enum logic [1:0] {
		CFG_AUTO4   = 2'h0,  // four sensors, automatic choice
		CFG_PAR_L12 = 2'h1,  // two-sensor parallel on lines one and two
		CFG_PAR_L1A = 2'h2,  // two-sensor parallel on line one and aux five
		CFG_PAR_L34 = 2'h3   // two-sensor parallel on lines three and four
	} mtam_cfg_t;

	// Supervisor states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,  // waiting for all sensors inactive
		ST_READY = 9'h002,  // armed, waiting for the first activation
		ST_PWAIT = 9'h004,  // parallel: measuring pair skew
		ST_SWAIT = 9'h008,  // sequential: waiting for the second sensor
		ST_START = 9'h010,  // start delay running
		ST_PMUTE = 9'h020,  // parallel muting
		ST_SMUTE = 9'h040,  // sequential muting
		ST_END   = 9'h080,  // end delay running, still muted
		ST_FAULT = 9'h100   // time-limit fault, outputs off
	} mtam_state_t;

	// Mapped muting sensors, bit 0 first in forward travel
	typedef struct packed {
		logic outer_sensor_b;
		logic inner_sensor_b;
		logic inner_sensor_a;
		logic outer_sensor_a;
	} mtam_sens_t;

	// Control word layout
	typedef struct packed {
		logic [21:0] rsvd_hi;
		logic        clr_ind_fault;  // write one: clear indicator fault
		logic        restart;        // write one: restart after a fault
		logic [3:0]  rsvd_lo;
		logic        ind_sup;        // supervise the muting indicator
		logic        ind_en;         // drive the muting indicator
		mtam_cfg_t   cfg;
	} mtam_ctrl_t;

	// Status word layout
	typedef struct packed {
		logic [11:0] rsvd;
		mtam_sens_t  sens;
		logic [1:0]  step;
		logic        handover;
		logic        par_mode;
		logic        ind_fault;
		logic        fault_e50;
		logic        muting;
		mtam_state_t state;
	} mtam_status_t;

endpackage
`default_nettype wire

// File: src/mtam_muting_supervisor.sv
// Muting supervisor: automatic parallel or sequential muting with time limit
//
// What this block does
// - Sequential: successive activations at least seq_min_gap_time apart, default 0 ms.
// - Parallel: pair activations at least par_min_skew_time apart, default 0 ms.
// - Parallel: reject pairs spaced beyond par_max_skew_time, default 2500 ms.
// - Parallel: one sensor lost longer than par_max_skew_time ends muting.
// - Muting beyond muting_time_limit ends muting, flags E50, switches outputs off.
// - Muting begins after start_delay: latency plus configurable on-time, default 0 ms.
// - Muting ends after end_delay: latency plus configurable off-time, default 100 ms.
// - Pair skew accepted only between minimum and maximum skew, inclusive.
// - After a fault, self reset after about 10 s unless key present.
// - After a fault, muting needs a restart and a fresh valid sequence.
// - A time limit of zero disables time-limit supervision.
// - Basic configuration maps sensor roles onto input lines; default automatic four-sensor.
// - On muting start drive the indicator if enabled, supervise it if enabled.
// - Automatic mode: an inner sensor first selects parallel muting.
// - Parallel muting starts when both inner sensors active with skew in window.
// - Parallel ends on both inner off plus end delay, or long single loss.
// - Parallel: single inner loss up to par_max_skew_time is tolerated.
// - Automatic mode: outer first selects sequential; forward order or its exact reverse.
// - Sequential: each activation in order and spaced by the minimum gap.
// - Sequential hands over only if all four sensors active together; else ends.
// - Sequential ends when third sensor off and end delay expires; then all inactive.
// - Sequential: sensor losses no longer than end delay are tolerated.
`timescale 1ns/1ps
`default_nettype none

module mtam_muting_supervisor
	import mtam_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = mtam_pkg::CYC_PER_MS_DFLT  // Clock cycles per millisecond
)(
	input  wire logic                     sys_clk_i,               // System clock, 125 MHz
	input  wire logic                     rst_i,                   // Synchronous reset, active high
	input  wire logic [mtam_pkg::ADDR_W-1:0] reg_addr_i,           // Register word address
	input  wire logic [31:0]              reg_wdata_i,             // Register write data
	input  wire logic                     reg_wr_i,                // Write strobe
	input  wire logic                     reg_rd_i,                // Read strobe
	output logic      [31:0]              reg_rdata_o,             // Read data, cycle after strobe
	input  wire logic                     input_line_one_i,        // Sensor input line one
	input  wire logic                     input_line_two_i,        // Sensor input line two
	input  wire logic                     input_line_three_i,      // Sensor input line three
	input  wire logic                     input_line_four_i,       // Sensor input line four
	input  wire logic                     input_aux_five_i,        // Auxiliary sensor input five
	input  wire logic                     field_clear_i,           // Protective field free
	input  wire logic                     param_key_present_i,     // Key occupies config port
	input  wire logic                     indicator_ok_i,          // Indicator lamp feedback
	output logic                          safety_switch_outputs_o, // Safety outputs on
	output logic                          muting_active_o,         // Protective function muted
	output logic                          muting_indicator_o,      // Muting indicator drive
	output logic                          fault_e50_o,             // Time-limit fault
	output logic                          indicator_fault_o        // Indicator supervision fault
);
	import mtam_pkg::*;

	// Configuration registers
	mtam_ctrl_t  ctrl_q;
	logic [31:0] seq_gap_q, par_min_q, par_max_q, limit_q, on_q, off_q;
	logic [31:0] rdata_q;

	// Supervisor state and counters
	mtam_state_t state_q, state_d;
	logic [1:0]  step_q, step_d;
	logic        dir_q, dir_d, par_q, par_d, ho_q, ho_d;
	logic [31:0] pre_q, t_cnt_q, drop_q, lim_q, flt_q;
	logic        safety_switch_outputs_q, ind_flt_q;

	// Millisecond timebase shared by every interval counter
	logic ms_tick;
	assign ms_tick = (pre_q == 32'(CYC_PER_MS - 1));

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			pre_q <= 32'h0000_0000;
		else
			pre_q <= ms_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
	end

	// Sensor roles from the basic configuration; two-sensor modes have no outers
	mtam_sens_t sens;
	logic [3:0] s_vec;
	logic       auto4;
	assign auto4 = (ctrl_q.cfg == CFG_AUTO4);
	assign sens.outer_sensor_a = auto4 & input_line_one_i;
	assign sens.inner_sensor_a = auto4 ? input_line_two_i :
		(ctrl_q.cfg == CFG_PAR_L34) ? input_line_three_i : input_line_one_i;
	assign sens.inner_sensor_b = auto4 ? input_line_three_i :
		(ctrl_q.cfg == CFG_PAR_L12) ? input_line_two_i :
		(ctrl_q.cfg == CFG_PAR_L1A) ? input_aux_five_i : input_line_four_i;
	assign sens.outer_sensor_b = auto4 & input_line_four_i;
	assign s_vec = sens;

	// Sensors in expected travel order; reverse travel reads the vector backwards
	logic [3:0] ord;
	for (genvar gi = 0; gi < 4; gi++)
	begin : g_ord
		assign ord[gi] = dir_q ? s_vec[3 - gi] : s_vec[gi];
	end

	// Sequence helpers: next expected sensor, any sensor beyond it, those already seen
	logic       nxt_act, later_act, all_idle, both_in, any_in, seen_ok;
	logic [3:0] later_mask, seen_mask;
	assign later_mask = 4'(4'hE << step_q);
	assign seen_mask  = 4'((4'h1 << step_q) - 4'h1);
	assign nxt_act    = ord[step_q];
	assign later_act  = |(ord & later_mask);
	assign seen_ok    = ((ord & seen_mask) == seen_mask);
	assign all_idle   = (s_vec == 4'h0);
	assign both_in    = sens.inner_sensor_a & sens.inner_sensor_b;
	assign any_in     = sens.inner_sensor_a | sens.inner_sensor_b;

	// Timing comparisons against the configured millisecond values
	logic gap_ok, skew_ok, skew_late, on_done, off_done, par_drop, seq_drop;
	logic par_lost, seq_lost, lim_hit, muting, auto_rst;
	assign gap_ok    = (t_cnt_q >= seq_gap_q);
	assign skew_ok   = (t_cnt_q >= par_min_q) && (t_cnt_q <= par_max_q);
	assign skew_late = (t_cnt_q > par_max_q);
	assign on_done   = (t_cnt_q >= on_q);
	assign off_done  = (t_cnt_q >= off_q);
	assign par_drop  = (state_q == ST_PMUTE) & (sens.inner_sensor_a ^ sens.inner_sensor_b);
	assign seq_drop  = (state_q == ST_SMUTE) & ~ho_q & ~seen_ok;
	assign par_lost  = par_drop & (drop_q > par_max_q);
	assign seq_lost  = seq_drop & (drop_q > off_q);
	assign muting    = (state_q == ST_PMUTE) | (state_q == ST_SMUTE) | (state_q == ST_END);
	assign lim_hit   = muting & (limit_q != LIMIT_OFF) & (lim_q >= limit_q);
	assign auto_rst  = (flt_q >= AUTO_RST_MS) & ~param_key_present_i;

	// Register decode
	logic wr_ctrl;
	mtam_ctrl_t wctrl;
	assign wctrl   = mtam_ctrl_t'(reg_wdata_i);
	assign wr_ctrl = reg_wr_i & (reg_addr_i == ADDR_CTRL);

	// Supervisor sequencing
	always_comb
	begin
		state_d = state_q;
		step_d  = step_q;
		dir_d   = dir_q;
		par_d   = par_q;
		ho_d    = ho_q;
		case (state_q)
			ST_IDLE:
				if (all_idle)
					state_d = ST_READY;
			ST_READY:
				if (any_in)
				begin
					state_d = ST_PWAIT;
					par_d   = 1'b1;
				end
				else if (sens.outer_sensor_a | sens.outer_sensor_b)
				begin
					state_d = ST_SWAIT;
					par_d   = 1'b0;
					ho_d    = 1'b0;
					dir_d   = ~sens.outer_sensor_a;
					step_d  = 2'h1;
				end
			ST_PWAIT:
				if (both_in)
					state_d = skew_ok ? ST_START : ST_IDLE;
				else if (skew_late | ~any_in)
					state_d = ST_IDLE;
			ST_SWAIT:
				if (later_act | ~ord[0])
					state_d = ST_IDLE;
				else if (nxt_act)
				begin
					state_d = gap_ok ? ST_START : ST_IDLE;
					step_d  = 2'h2;
				end
			ST_START:
				if (par_q ? ~both_in : ~(ord[0] & ord[1]))
					state_d = ST_IDLE;
				else if (on_done)
					state_d = par_q ? ST_PMUTE : ST_SMUTE;
			ST_PMUTE:
				if (~any_in)
					state_d = ST_END;
				else if (par_lost)
					state_d = ST_IDLE;
			ST_SMUTE:
				if (ho_q)
					state_d = ord[2] ? ST_SMUTE : ST_END;
				else if (seq_lost | later_act)
					state_d = ST_IDLE;
				else if (nxt_act)
				begin
					if (~gap_ok)
						state_d = ST_IDLE;
					else if (step_q == 2'h3)
					begin
						if (&ord)
							ho_d = 1'b1;
						else
							state_d = ST_IDLE;
					end
					else
						step_d = step_q + 2'h1;
				end
			ST_END:
				if (par_q ? any_in : (ho_q & ord[2]))
					state_d = par_q ? ST_PMUTE : ST_SMUTE;
				else if (off_done)
					state_d = ST_IDLE;
			ST_FAULT:
				if (auto_rst | (wr_ctrl & wctrl.restart))
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
		if (lim_hit)
			state_d = ST_FAULT;
	end

	// Interval counter restarts on every state change and sequence step
	logic t_clr;
	assign t_clr = (state_d != state_q) | (step_d != step_q);

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
			step_q  <= 2'h0;
			dir_q   <= 1'b0;
			par_q   <= 1'b0;
			ho_q    <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			step_q  <= step_d;
			dir_q   <= dir_d;
			par_q   <= par_d;
			ho_q    <= ho_d;
		end
	end

	// Millisecond counters; they saturate so a stuck input cannot wrap them
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | t_clr)
			t_cnt_q <= 32'h0000_0000;
		else if (ms_tick & ~&t_cnt_q)
			t_cnt_q <= t_cnt_q + 32'h0000_0001;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | ~(par_drop | seq_drop))
			drop_q <= 32'h0000_0000;
		else if (ms_tick & ~&drop_q)
			drop_q <= drop_q + 32'h0000_0001;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | ~muting)
			lim_q <= 32'h0000_0000;
		else if (ms_tick & ~&lim_q)
			lim_q <= lim_q + 32'h0000_0001;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | (state_q != ST_FAULT))
			flt_q <= 32'h0000_0000;
		else if (ms_tick & ~&flt_q)
			flt_q <= flt_q + 32'h0000_0001;
	end

	// Safety outputs: off in a fault, otherwise on while the field is free or muted
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			safety_switch_outputs_q <= 1'b0;
		else
			safety_switch_outputs_q <= (state_d != ST_FAULT) & (field_clear_i | muting);
	end

	// Indicator supervision; a new fault wins over a clear in the same cycle
	logic ind_set;
	assign ind_set = ctrl_q.ind_sup & muting_indicator_o & ~indicator_ok_i;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			ind_flt_q <= 1'b0;
		else
			ind_flt_q <= ind_set | (ind_flt_q & ~(wr_ctrl & wctrl.clr_ind_fault));
	end

	// Register writes; the pulse bits of the control word are never stored
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q    <= '0;
			seq_gap_q <= RST_SEQ_GAP;
			par_min_q <= RST_PAR_MIN;
			par_max_q <= RST_PAR_MAX;
			limit_q   <= RST_LIMIT;
			on_q      <= RST_ON_TIME;
			off_q     <= RST_OFF_TIME;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == ADDR_CTRL)
			begin
				ctrl_q.cfg    <= wctrl.cfg;
				ctrl_q.ind_en <= wctrl.ind_en;
				ctrl_q.ind_sup <= wctrl.ind_sup;
			end
			if (reg_addr_i == ADDR_SEQ_GAP)
				seq_gap_q <= reg_wdata_i;
			if (reg_addr_i == ADDR_PAR_MIN)
				par_min_q <= reg_wdata_i;
			if (reg_addr_i == ADDR_PAR_MAX)
				par_max_q <= reg_wdata_i;
			if (reg_addr_i == ADDR_LIMIT)
				limit_q <= reg_wdata_i;
			if (reg_addr_i == ADDR_ON_TIME)
				on_q <= reg_wdata_i;
			if (reg_addr_i == ADDR_OFF_TIM)
				off_q <= reg_wdata_i;
		end
	end

	// Read path: data stand only in the cycle after the strobe
	mtam_status_t stat;
	logic [31:0]  rd_mux;
	assign stat = '{rsvd: '0, sens: sens, step: step_q, handover: ho_q, par_mode: par_q,
		ind_fault: ind_flt_q, fault_e50: fault_e50_o, muting: muting, state: state_q};
	assign rd_mux = (reg_addr_i == ADDR_CTRL)    ? 32'(ctrl_q)  :
		(reg_addr_i == ADDR_SEQ_GAP) ? seq_gap_q :
		(reg_addr_i == ADDR_PAR_MIN) ? par_min_q :
		(reg_addr_i == ADDR_PAR_MAX) ? par_max_q :
		(reg_addr_i == ADDR_LIMIT)   ? limit_q   :
		(reg_addr_i == ADDR_ON_TIME) ? on_q      :
		(reg_addr_i == ADDR_OFF_TIM) ? off_q     : 32'(stat);

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | ~reg_rd_i)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= rd_mux;
	end

	// Outputs
	assign reg_rdata_o             = rdata_q;
	assign safety_switch_outputs_o = safety_switch_outputs_q;
	assign muting_active_o         = muting;
	assign muting_indicator_o      = muting & ctrl_q.ind_en;
	assign fault_e50_o             = (state_q == ST_FAULT);
	assign indicator_fault_o       = ind_flt_q;

	// Checks on the supervisor's own behaviour
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	property p_fault_safety_switch_outputs_off;
		(state_q == ST_FAULT) |-> !safety_switch_outputs_o && !muting_active_o;
	endproperty
	a_fault_safety_switch_outputs_off: assert property (p_fault_safety_switch_outputs_off) else $error("Outputs on");
	property p_limit_fault;
		lim_hit |=> (state_q == ST_FAULT) ##1 !safety_switch_outputs_o;
	endproperty
	a_limit_fault: assert property (p_limit_fault) else $error("Limit ignored");
	property p_limit_off;
		$rose(fault_e50_o) |-> $past(limit_q) != LIMIT_OFF;
	endproperty
	a_limit_off: assert property (p_limit_off) else $error("Fault with limit off");
	property p_start_delay;
		(state_q == ST_START) ##1 (state_q == ST_PMUTE || state_q == ST_SMUTE)
			|-> $past(t_cnt_q) >= $past(on_q);
	endproperty
	a_start_delay: assert property (p_start_delay) else $error("Early start");
	property p_skew_window;
		(state_q == ST_PWAIT) ##1 (state_q == ST_START)
			|-> $past(t_cnt_q) >= $past(par_min_q) && $past(t_cnt_q) <= $past(par_max_q);
	endproperty
	a_skew_window: assert property (p_skew_window) else $error("Bad pair skew");
	property p_par_loss;
		par_lost && !lim_hit |=> (state_q == ST_IDLE) && !muting_active_o;
	endproperty
	a_par_loss: assert property (p_par_loss) else $error("Inner loss kept muting");
	property p_end_delay;
		(state_q == ST_END) ##1 (state_q == ST_IDLE) |-> $past(t_cnt_q) >= $past(off_q);
	endproperty
	a_end_delay: assert property (p_end_delay) else $error("Muting ended early");
	property p_fault_exit;
		(state_q == ST_FAULT) ##1 (state_q != ST_FAULT) |-> (state_q == ST_IDLE);
	endproperty
	a_fault_exit: assert property (p_fault_exit) else $error("Bad fault exit");
	property p_handover;
		$rose(ho_q) |-> $past(ord) == 4'hF;
	endproperty
	a_handover: assert property (p_handover) else $error("Handover not all four");
	// A dead lamp under supervision must raise the sticky flag on the next edge
	property p_indicator;
		ctrl_q.ind_sup && muting_indicator_o && !indicator_ok_i |=> indicator_fault_o;
	endproperty
	a_indicator: assert property (p_indicator) else $error("Lamp fault missed");

	c_par_mute: cover property ((state_q == ST_PWAIT) ##1 (state_q == ST_START));
	c_seq_ho:   cover property ($rose(ho_q));
	c_fault:    cover property ($rose(fault_e50_o));
	c_end_ok:   cover property ((state_q == ST_END) ##1 (state_q == ST_IDLE));

endmodule // mtam_muting_supervisor
`default_nettype wire

// File: verif/mtam_sensor_model.sv
// Behavioural muting light barriers wired onto the input lines
`timescale 1ns/1ps
`default_nettype none
module mtam_sensor_model
	import mtam_pkg::*;
(
	input  wire mtam_pkg::mtam_sens_t sens_i,             // Barriers seeing the object
	output logic                      line_one_o,         // Input line one
	output logic                      line_two_o,         // Input line two
	output logic                      line_three_o,       // Input line three
	output logic                      line_four_o,        // Input line four
	output logic                      aux_five_o          // Auxiliary line five
);
	// Four-sensor wiring; the aux line has no barrier here, so it rests low
	assign line_one_o   = sens_i.outer_sensor_a;
	assign line_two_o   = sens_i.inner_sensor_a;
	assign line_three_o = sens_i.inner_sensor_b;
	assign line_four_o  = sens_i.outer_sensor_b;
	assign aux_five_o   = 1'b0;
endmodule // mtam_sensor_model
`default_nettype wire

// File: verif/mtam_muting_supervisor_tb.sv
// Self-checking bench for the muting supervisor
`timescale 1ns/1ps
`default_nettype none
module mtam_muting_supervisor_tb;
	import mtam_pkg::*;
	localparam int unsigned CPM = 10;  // Short millisecond keeps the run brief
	logic        clk, rst, wr_s, rd_s, l1, l2, l3, l4, l5, fclr, key, iok;
	logic        ssw, mute, ind, e50, indf;
	logic [2:0]  addr;
	logic [31:0] wdat, rdat, rv;
	logic [31:0] dflt [7] = '{32'h0, 32'h0, 32'h0, 32'h9C4, 32'h927C0, 32'h0, 32'h64};
	mtam_sens_t  sens;
	int          fails, tests_run;

	mtam_sensor_model i_sens (.sens_i(sens), .line_one_o(l1), .line_two_o(l2),
		.line_three_o(l3), .line_four_o(l4), .aux_five_o(l5));
	mtam_muting_supervisor #(.CYC_PER_MS(CPM)) i_dut (.sys_clk_i(clk), .rst_i(rst),
		.reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
		.reg_rdata_o(rdat), .input_line_one_i(l1), .input_line_two_i(l2),
		.input_line_three_i(l3), .input_line_four_i(l4), .input_aux_five_i(l5),
		.field_clear_i(fclr), .param_key_present_i(key), .indicator_ok_i(iok),
		.safety_switch_outputs_o(ssw), .muting_active_o(mute), .muting_indicator_o(ind),
		.fault_e50_o(e50), .indicator_fault_o(indf));

	// 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Ends one step past the edge so outputs have settled
	task automatic ms(input int n);
		repeat (n * CPM) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe edge
	task automatic rd(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 rv = rdat;
	endtask

	task automatic put(input logic [3:0] s);
		@(posedge clk);
		sens <= s;
	endtask

	// Inner pair with a 4 ms skew, then long enough for the on-time
	task automatic par_start();
		put(4'h2);
		ms(4);
		put(4'h6);
		ms(6);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog well beyond the few thousand cycles the tests need
	initial
	begin
		repeat (30000) @(posedge clk);
		fails++;
		end_sim();
	end

	initial
	begin
		{rst, wr_s, rd_s, addr, wdat, sens, fclr, key, iok} = {1'b1, 41'h0, 3'h7};
		fails = 0;
		tests_run = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// Factory values, and a write to the status word that must be ignored
		for (int i = 0; i < 7; i++)
		begin
			rd(3'(i));
			chk(rv, dflt[i]);
		end
		wr(3'h7, 32'hFFFF_FFFF);
		rd(3'h7);
		chk(rv[8:0], 9'h002);
		// Short times: gap 2, min skew 2, max skew 20, limit 100, on 3, off 5
		dflt = '{32'h4, 32'h2, 32'h2, 32'h14, 32'h64, 32'h3, 32'h5};
		for (int i = 0; i < 7; i++)
			wr(3'(i), dflt[i]);
		// Parallel: start delay, indicator, single dropout, end delay
		put(4'h2);
		ms(4);
		put(4'h6);
		ms(1);
		chk(mute, 1'b0);
		ms(5);
		chk({mute, ind, ssw}, 3'h7);
		rd(3'h7);
		chk(rv[12], 1'b1);
		put(4'h4);
		ms(10);
		chk(mute, 1'b1);
		put(4'h6);
		ms(2);
		put(4'h0);
		ms(2);
		chk(mute, 1'b1);
		ms(6);
		chk(mute, 1'b0);
		// Skew above the maximum, then below the minimum
		put(4'h2);
		ms(25);
		put(4'h6);
		ms(10);
		chk(mute, 1'b0);
		put(4'h0);
		ms(2);
		put(4'h6);
		ms(10);
		chk(mute, 1'b0);
		put(4'h0);
		ms(2);
		// One inner sensor lost beyond the maximum skew
		par_start();
		put(4'h2);
		ms(25);
		chk(mute, 1'b0);
		put(4'h0);
		ms(2);
		// Sequential forward, short outer dropout, handover, third sensor off
		put(4'h1);
		ms(3);
		put(4'h3);
		ms(6);
		chk(mute, 1'b1);
		put(4'h2);
		ms(2);
		put(4'h3);
		ms(1);
		chk(mute, 1'b1);
		put(4'h7);
		ms(3);
		put(4'hF);
		ms(3);
		rd(3'h7);
		chk(rv[13:12], 2'h2);
		put(4'hE);
		put(4'hC);
		ms(3);
		put(4'h8);
		ms(2);
		chk(mute, 1'b1);
		ms(6);
		chk(mute, 1'b0);
		put(4'h0);
		ms(2);
		// Reverse travel, first sensor lost before all four meet
		put(4'h8);
		ms(3);
		put(4'hC);
		ms(6);
		chk(mute, 1'b1);
		put(4'hE);
		ms(3);
		put(4'h6);
		ms(10);
		chk(mute, 1'b0);
		put(4'h0);
		ms(2);
		// Second sensor too soon after the first
		put(4'h1);
		put(4'h3);
		ms(10);
		chk(mute, 1'b0);
		put(4'h0);
		ms(2);
		// Time limit fault, then restart without a fresh sequence
		par_start();
		ms(90);
		chk(mute, 1'b1);
		ms(12);
		chk({e50, mute, ssw}, 3'h4);
		wr(3'h0, 32'h104);
		ms(5);
		chk({e50, mute}, 2'h0);
		put(4'h0);
		ms(2);
		// Zero limit switches the supervision off
		wr(3'h4, 32'h0);
		par_start();
		ms(120);
		chk({e50, mute}, 2'h1);
		put(4'h0);
		ms(8);
		// Supervised indicator with a dead lamp; outputs held by muting alone
		wr(3'h0, 32'h0000_000C);
		iok <= 1'b0;
		fclr <= 1'b0;
		par_start();
		chk({indf, ssw}, 2'h3);
		// A clear loses while the lamp is still dead; with the lamp back it wins
		wr(3'h0, 32'h0000_020C);
		ms(1);
		chk(indf, 1'b1);
		put(4'h6);
		iok <= 1'b1;
		wr(3'h0, 32'h0000_020C);
		ms(1);
		chk(indf, 1'b0);
		// Muting over with the field blocked: outputs fall
		put(4'h0);
		ms(8);
		chk({mute, ssw}, 2'h0);
		// Two-sensor parallel on lines one and two, outers ignored
		wr(3'h0, 32'h0000_0001);
		put(4'h1);
		ms(4);
		put(4'h3);
		ms(6);
		rd(3'h7);
		chk({rv[19:16], rv[12], rv[9]}, 6'h1B);
		put(4'h0);
		ms(8);
		end_sim();
	end
endmodule // mtam_muting_supervisor_tb
`default_nettype wire
